// *** cnmc_core_model.sv ***
/* Model of the controller core and the other nodes on the bus.
   Assumes the bench calls send_rx to put a frame on the receive side. */
`timescale 1ns/10ps
`default_nettype none
module cnmc_core_model
  import cnmc_pkg::*;
(
  input  wire logic   clock_in,
  input  wire logic   tx_valid_in,
  output var logic    tx_ready_out,
  output cnmc_frame_s rx_frame_out,
  output var logic    rx_valid_out
);
  initial begin
    tx_ready_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_frame_out = '0;
  end
  ////////////////////////////////////////////////
  // Accept after a random stall so holding is exercised
  always @(posedge clock_in) begin
    tx_ready_out <= tx_valid_in && !tx_ready_out && ($urandom_range(2) == 0);
  end
  // One-cycle frame; stale content is inverted so it never looks valid
  task automatic send_rx(input cnmc_frame_s f);
    @(posedge clock_in);
    rx_frame_out <= f;
    rx_valid_out <= 1'b1;
    @(posedge clock_in);
    rx_valid_out <= 1'b0;
    rx_frame_out <= ~f;
  endtask : send_rx
endmodule : cnmc_core_model
`default_nettype wire

// *** cnmc_map.svh ***
/*
  Constant map for the CAN node mode and configuration block.
  Assumes it is included by its bare name from the package and design files.
*/
`ifndef CNMC_MAP_SVH
`define CNMC_MAP_SVH

// Register word offsets on the Avalon-MM slave
`define CNMC_OFF_MODE       4'h0
`define CNMC_OFF_NODE       4'h1
`define CNMC_OFF_RATE       4'h2
`define CNMC_OFF_HB_PERIOD  4'h3
`define CNMC_OFF_PDO_PERIOD 4'h4
`define CNMC_OFF_LISTEN     4'h5
`define CNMC_OFF_STATUS     4'h6
`define CNMC_OFF_TX_REQ     4'h7
`define CNMC_OFF_RX_ID      4'h8
`define CNMC_OFF_RX_DATA_LO 4'h9
`define CNMC_OFF_RX_DATA_HI 4'ha
`define CNMC_OFF_TX_DATA_LO 4'hb
`define CNMC_OFF_TX_DATA_HI 4'hc

// Reset values and node number range
`define CNMC_RST_NODE       7'h01
`define CNMC_RST_RATE       3'h4
`define CNMC_NODE_MIN       7'h01
`define CNMC_NODE_MAX       7'h7e

// Identifier bases and payloads
`define CNMC_ID_HEARTBEAT   11'h700
`define CNMC_ID_TPDO1       11'h180
`define CNMC_HB_STATE       8'h05
`define CNMC_HB_LEN         4'h1
`define CNMC_PDO_LEN        4'h8

// Identifier field layout
`define CNMC_SENDER_MSB     6
`define CNMC_TYPE_LSB       7

// One period tick is 1 ms at 50 MHz
`define CNMC_CLK_HZ         50000000
`define CNMC_TICK_US        1000
`define CNMC_TICK_CYCLES    ((`CNMC_CLK_HZ / 1000000) * `CNMC_TICK_US)

`endif

// *** cnmc_node.sv ***
/*
  CAN node mode and configuration: Avalon-MM registers, heartbeat and PDO
  schedulers, receive filter and USB exclusion.
  Assumes a CAN controller core beside it that sends one frame per accepted
  request and delivers received frames as valid-qualified words.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cnmc_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - Mode register selects four modes or off
// - Own node number clamped 1 to 126
// - Five bit rates, default 125 kbit/s
// - Heartbeat id 0x700 plus node, byte 0x05
// - Heartbeat periodic in every mode but off, zero disables
// - PDO frames at send period, zero disables
// - PDO mode accepts only listened sender
// - Raw mode: filter zero takes all
// - PDO mode streams TPDOs autonomously; mesh sends heartbeats only
// - Every enabled mode sends heartbeats; user frames on request except in mesh
// - Exclusive models enable CAN without USB
// - USB seen in exclusive models disables CAN until restart
// - Identifier: sender bits 0-6, type 7-10
// - Four TPDOs in turn, 0x180 to 0x480
module cnmc_node
  import cnmc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        usb_exclusive_in,
  input  wire logic        usb_present_in,
  output logic             can_enable_out,
  output cnmc_rate_e       bit_rate_out,
  output cnmc_frame_s      tx_frame_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  input  wire cnmc_frame_s rx_frame_in,
  input  wire logic        rx_valid_in,
  output logic             rx_stored_out,
  output logic             mesh_active_out
);

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers

  cnmc_mode_e     mode;
  logic [6:0]     own_node_number;
  cnmc_rate_e     bit_rate;
  logic [15:0]    hb_period;
  logic [15:0]    pdo_send_period;
  logic [6:0]     listen_sender_filter;
  cnmc_frame_s    user_frame;
  logic           user_req;
  cnmc_frame_s    rx_hold;
  logic           rx_full;
  logic           usb_sync1;
  logic           usb_sync2;
  logic           usb_lock;
  logic           bus_done;
  logic           wr_go;
  logic           rd_go;
  logic [6:0]     next_node;
  logic           user_set;

  // One wait cycle per access so read data come from a flop
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !bus_done;
  assign wr_go               = avs_write_in && bus_done;
  assign rd_go               = avs_read_in && bus_done;

  // Send request; a new one written as the old one leaves keeps its place
  assign user_set = wr_go && (avs_address_in == `CNMC_OFF_TX_REQ) &&
                    (mode != CNMC_MODE_MESH);

  always_ff @(posedge clock_in) begin
    if (!rstn_in) bus_done <= 1'b0;
    else          bus_done <= (avs_read_in || avs_write_in) && !bus_done;
  end

  // Out-of-range node numbers saturate rather than being dropped
  always_comb begin
    next_node = avs_writedata_in[6:0];
    if (next_node < `CNMC_NODE_MIN)      next_node = `CNMC_NODE_MIN;
    else if (next_node > `CNMC_NODE_MAX) next_node = `CNMC_NODE_MAX;
  end

  // Configuration writes; byte lane 0 carries every narrow field
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      mode                 <= CNMC_MODE_OFF;
      own_node_number      <= `CNMC_RST_NODE;
      bit_rate             <= CNMC_RATE_125;
      hb_period            <= 16'h0000;
      pdo_send_period      <= 16'h0000;
      listen_sender_filter <= 7'h00;
    end else if (wr_go && avs_byteenable_in[0]) begin
      case (avs_address_in)
        `CNMC_OFF_MODE: begin
          if (avs_writedata_in[2:0] <= 3'h4) mode <= cnmc_mode_e'(avs_writedata_in[2:0]);
        end
        `CNMC_OFF_NODE:       own_node_number <= next_node;
        `CNMC_OFF_RATE: begin
          if (avs_writedata_in[2:0] <= 3'h4) bit_rate <= cnmc_rate_e'(avs_writedata_in[2:0]);
        end
        `CNMC_OFF_HB_PERIOD:  hb_period <= avs_writedata_in[15:0];
        `CNMC_OFF_PDO_PERIOD: pdo_send_period <= avs_writedata_in[15:0];
        `CNMC_OFF_LISTEN:     listen_sender_filter <= avs_writedata_in[6:0];
        default: ;
      endcase
    end
  end

  // User frame staging; the request is raised by writing the id register
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      user_frame <= '0;
    end else if (wr_go) begin
      case (avs_address_in)
        `CNMC_OFF_TX_REQ: begin
          user_frame.id  <= avs_writedata_in[10:0];
          user_frame.len <= avs_writedata_in[19:16];
        end
        `CNMC_OFF_TX_DATA_LO: user_frame.data[31:0]  <= avs_writedata_in;
        `CNMC_OFF_TX_DATA_HI: user_frame.data[63:32] <= avs_writedata_in;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // USB exclusion

  // Two-flop synchroniser for the asynchronous USB detect pin
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      usb_sync1 <= 1'b0;
      usb_sync2 <= 1'b0;
    end else begin
      usb_sync1 <= usb_present_in;
      usb_sync2 <= usb_sync1;
    end
  end

  // Latch until reset: unplugging alone never brings CAN back
  always_ff @(posedge clock_in) begin
    if (!rstn_in) usb_lock <= 1'b0;
    else if (usb_exclusive_in && usb_sync2) usb_lock <= 1'b1;
  end

  assign can_enable_out  = (mode != CNMC_MODE_OFF) && !usb_lock &&
                           !(usb_exclusive_in && usb_sync2);
  assign bit_rate_out    = bit_rate;
  assign mesh_active_out = can_enable_out && (mode == CNMC_MODE_MESH);

  //////////////////////////////////////////////////////////////////////////
  // Period timers

  logic [15:0] tick_count;
  logic        tick;
  logic        hb_fire;
  logic        pdo_fire;
  logic        hb_pend;
  logic        pdo_pend;
  logic [1:0]  pdo_index;
  logic        pdo_run;

  // Shared 1 ms tick keeps both period counters narrow
  always_ff @(posedge clock_in) begin
    if (!rstn_in || tick_count == 16'(`CNMC_TICK_CYCLES - 1)) tick_count <= 16'h0000;
    else tick_count <= tick_count + 16'h0001;
  end
  assign tick = (tick_count == 16'(`CNMC_TICK_CYCLES - 1));

  assign pdo_run = can_enable_out && (mode == CNMC_MODE_PDO);

  cnmc_period u_hb (
    .clock_in  (clock_in),
    .rstn_in   (rstn_in),
    .tick_in   (tick),
    .run_in    (can_enable_out),
    .period_in (hb_period),
    .fire_out  (hb_fire)
  );

  cnmc_period u_pdo (
    .clock_in  (clock_in),
    .rstn_in   (rstn_in),
    .tick_in   (tick),
    .run_in    (pdo_run),
    .period_in (pdo_send_period),
    .fire_out  (pdo_fire)
  );

  //////////////////////////////////////////////////////////////////////////
  // Transmit arbiter: heartbeat first, then PDO, then user request

  cnmc_tx_state_e tx_state;

  always_ff @(posedge clock_in) begin
    if (!rstn_in || !can_enable_out) begin
      hb_pend   <= 1'b0;
      pdo_pend  <= 1'b0;
      user_req  <= 1'b0;
      pdo_index <= 2'h0;
      tx_state  <= CNMC_TX_IDLE;
      tx_valid_out <= 1'b0;
      tx_frame_out <= '0;
    end else begin
      // New events win over the clear of the same cycle
      if (hb_fire) hb_pend <= 1'b1;
      if (pdo_fire) pdo_pend <= 1'b1;
      if (user_set) user_req <= 1'b1;
      case (tx_state)
        CNMC_TX_IDLE: begin
          if (hb_pend) begin
            hb_pend <= hb_fire;
            tx_frame_out.id   <= `CNMC_ID_HEARTBEAT + {4'h0, own_node_number};
            tx_frame_out.len  <= `CNMC_HB_LEN;
            tx_frame_out.data <= {56'h0, `CNMC_HB_STATE};
            tx_valid_out <= 1'b1;
            tx_state     <= CNMC_TX_BUSY;
          end else if (pdo_pend) begin
            pdo_pend <= pdo_fire;
            tx_frame_out.id <= `CNMC_ID_TPDO1 + {1'b0, pdo_index, 8'h00} +
                               {4'h0, own_node_number};
            tx_frame_out.len  <= `CNMC_PDO_LEN;
            tx_frame_out.data <= user_frame.data;
            pdo_index    <= pdo_index + 2'h1;
            tx_valid_out <= 1'b1;
            tx_state     <= CNMC_TX_BUSY;
          end else if (user_req) begin
            user_req     <= user_set;
            tx_frame_out <= user_frame;
            tx_valid_out <= 1'b1;
            tx_state     <= CNMC_TX_BUSY;
          end
        end
        CNMC_TX_BUSY: begin
          if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
            tx_state     <= CNMC_TX_IDLE;
          end
        end
        default: tx_state <= CNMC_TX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive filter and single-frame holding buffer

  logic [6:0] rx_sender;
  logic       rx_accept;

  assign rx_sender = rx_frame_in.id[`CNMC_SENDER_MSB:0];

  // Decide before storing so a rejected frame never overwrites the hold
  always_comb begin
    case (mode)
      CNMC_MODE_PDO: rx_accept = (rx_sender == listen_sender_filter);
      CNMC_MODE_RAW: rx_accept = (listen_sender_filter == 7'h00) ||
                                 (rx_sender == listen_sender_filter);
      default:       rx_accept = 1'b0;
    endcase
  end

  // Hold is locked while full; reading the id frees it for the next one
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      rx_hold       <= '0;
      rx_full       <= 1'b0;
      rx_stored_out <= 1'b0;
    end else begin
      rx_stored_out <= 1'b0;
      if (rx_valid_in && can_enable_out && rx_accept && !rx_full) begin
        rx_hold       <= rx_frame_in;
        rx_full       <= 1'b1;
        rx_stored_out <= 1'b1;
      end else if (rd_go && avs_address_in == `CNMC_OFF_RX_ID) begin
        rx_full <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data path; unmapped offsets read as zero

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !bus_done) begin
      case (avs_address_in)
        `CNMC_OFF_MODE:       avs_readdata_out <= {29'h0, mode};
        `CNMC_OFF_NODE:       avs_readdata_out <= {25'h0, own_node_number};
        `CNMC_OFF_RATE:       avs_readdata_out <= {29'h0, bit_rate};
        `CNMC_OFF_HB_PERIOD:  avs_readdata_out <= {16'h0, hb_period};
        `CNMC_OFF_PDO_PERIOD: avs_readdata_out <= {16'h0, pdo_send_period};
        `CNMC_OFF_LISTEN:     avs_readdata_out <= {25'h0, listen_sender_filter};
        `CNMC_OFF_STATUS:     avs_readdata_out <= {27'h0, tx_valid_out, usb_lock,
                                                   rx_full, can_enable_out, user_req};
        `CNMC_OFF_RX_ID:      avs_readdata_out <= rx_full ?
                                {12'h0, rx_hold.len, 5'h0, rx_hold.id} : 32'h0000_0000;
        `CNMC_OFF_RX_DATA_LO: avs_readdata_out <= rx_hold.data[31:0];
        `CNMC_OFF_RX_DATA_HI: avs_readdata_out <= rx_hold.data[63:32];
        default:              avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule : cnmc_node

`default_nettype wire

// *** cnmc_period.sv ***
/*
  Millisecond period timer that pulses once per programmed period.
  Assumes a shared 1 ms tick from the same clock; zero period is silent.
*/
`timescale 1ns/10ps
`default_nettype none

module cnmc_period
  import cnmc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic        tick_in,
  input  wire logic        run_in,
  input  wire logic [15:0] period_in,
  output logic             fire_out
);

  logic [15:0] count;

  // Count ticks; restart whenever stopped so a new period starts clean
  always_ff @(posedge clock_in) begin
    if (!rstn_in || !run_in || period_in == 16'h0000) begin
      count    <= 16'h0000;
      fire_out <= 1'b0;
    end else if (tick_in) begin
      if (count + 16'h0001 >= period_in) begin
        count    <= 16'h0000;
        fire_out <= 1'b1;
      end else begin
        count    <= count + 16'h0001;
        fire_out <= 1'b0;
      end
    end else begin
      fire_out <= 1'b0;
    end
  end

endmodule : cnmc_period

`default_nettype wire

// *** cnmc_pkg.sv ***
/*
  Types for the CAN node mode and configuration block.
  Assumes cnmc_map.svh is reachable by bare name.
*/
`include "cnmc_map.svh"

package cnmc_pkg;

  // Operating mode; off blocks every frame
  typedef enum logic [2:0] {
    CNMC_MODE_OFF    = 3'b000,
    CNMC_MODE_RAW    = 3'b001,
    CNMC_MODE_PDO    = 3'b010,
    CNMC_MODE_COPEN  = 3'b011,
    CNMC_MODE_MESH   = 3'b100
  } cnmc_mode_e;

  // Bit rate code presented to the controller core
  typedef enum logic [2:0] {
    CNMC_RATE_1000 = 3'b000,
    CNMC_RATE_800  = 3'b001,
    CNMC_RATE_500  = 3'b010,
    CNMC_RATE_250  = 3'b011,
    CNMC_RATE_125  = 3'b100
  } cnmc_rate_e;

  // One classic data frame
  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  len;
    logic [63:0] data;
  } cnmc_frame_s;

  // Transmit arbiter states
  typedef enum logic [1:0] {
    CNMC_TX_IDLE = 2'b00,
    CNMC_TX_BUSY = 2'b01
  } cnmc_tx_state_e;

endpackage : cnmc_pkg

// *** cnmc_sva.sv ***
/* Port checker for the CAN node block.
   Assumes one clock and a synchronous active-low reset; bound below. */
`timescale 1ns/10ps
`default_nettype none
module cnmc_sva
  import cnmc_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        usb_exclusive_in,
  input wire logic        usb_present_in,
  input wire logic        can_enable_out,
  input wire cnmc_rate_e  bit_rate_out,
  input wire cnmc_frame_s tx_frame_out,
  input wire logic        tx_valid_out,
  input wire logic        tx_ready_in,
  input wire logic        rx_valid_in,
  input wire logic        rx_stored_out,
  input wire logic        mesh_active_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic [2:0] usb_sh;
  logic       usb_lat;
  ////////////////////////////////////////////////
  // USB history, one cycle slower than the pin sync so no false alarm
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      usb_sh  <= 3'h0;
      usb_lat <= 1'b0;
    end else begin
      usb_sh  <= {usb_sh[1:0], usb_exclusive_in & usb_present_in};
      usb_lat <= usb_lat | usb_sh[2];
    end
  end
  ////////////////////////////////////////////////
  // Bus timing, mode gating, frame shape and USB lock
  a_wait_first: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("no wait state on new request");
  a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("wait state longer than one cycle");
  a_off_quiet: assert property (!can_enable_out |=> !tx_valid_out && !rx_stored_out)
    else $error("traffic while disabled");
  a_hb_frame: assert property (tx_valid_out && tx_frame_out.id[10:7] == 4'he
    |-> tx_frame_out.len == 4'h1 && tx_frame_out.data[7:0] == 8'h05
    && tx_frame_out.id[6:0] inside {[7'h01:7'h7e]}) else $error("bad heartbeat frame");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in && can_enable_out
    |=> tx_valid_out && $stable(tx_frame_out)) else $error("frame dropped before accept");
  a_rx_cause: assert property (rx_stored_out |-> $past(rx_valid_in) && $past(can_enable_out))
    else $error("store without enabled receive");
  a_usb_lock: assert property (usb_sh[2] || usb_lat |-> !can_enable_out)
    else $error("CAN enabled after USB seen");
  a_rate_reset: assert property ($rose(rstn_in) |-> bit_rate_out == CNMC_RATE_125)
    else $error("bit rate not default after reset");
  a_mesh_en: assert property (mesh_active_out |-> can_enable_out)
    else $error("mesh active while disabled");
  c_rx: cover property (rx_stored_out);
  c_tx: cover property (tx_valid_out && tx_ready_in);
  c_mesh: cover property (mesh_active_out);
endmodule : cnmc_sva
bind cnmc_node cnmc_sva u_sva (.clock_in, .rstn_in, .avs_read_in, .avs_write_in,
  .avs_waitrequest_out, .usb_exclusive_in, .usb_present_in, .can_enable_out, .bit_rate_out,
  .tx_frame_out, .tx_valid_out, .tx_ready_in, .rx_valid_in, .rx_stored_out, .mesh_active_out);
`default_nettype wire

// *** tb_top.sv ***
/* Self-checking bench for cnmc_node.
   Assumes the core model on the frame side and a 50 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cnmc_pkg::*;
  logic        clock_in, rstn_in, read, write, usb_excl, usb_pres;
  logic        wait_req, can_en, tx_valid, tx_ready, rx_valid, rx_stored, mesh_act;
  logic [3:0]  address;
  logic [31:0] wdata, rdata, lo, hi;
  cnmc_rate_e  rate;
  cnmc_frame_s tx_frame, rx_frame;
  cnmc_frame_s exp_tx[$];
  logic [31:0] exp_rd[$];
  int          err_count, checks, stored_n;
  logic [6:0]  nv[3] = '{7'h00, 7'h7f, 7'h05};
  logic [6:0]  ne[3] = '{7'h01, 7'h7e, 7'h05};
  cnmc_node dut (.clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(address),
    .avs_read_in(read), .avs_write_in(write), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .usb_exclusive_in(usb_excl), .usb_present_in(usb_pres), .can_enable_out(can_en),
    .bit_rate_out(rate), .tx_frame_out(tx_frame), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .rx_frame_in(rx_frame), .rx_valid_in(rx_valid),
    .rx_stored_out(rx_stored), .mesh_active_out(mesh_act));
  cnmc_core_model core (.clock_in(clock_in), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .rx_frame_out(rx_frame), .rx_valid_out(rx_valid));
  ////////////////////////////////////////////////
  // Clock, 20 ns period
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    address <= a;
    wdata <= d;
    write <= w;
    read <= !w;
    do @(posedge clock_in); while (wait_req !== 1'b0);
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clock_in);
    @(negedge clock_in);
  endtask : settle
  // Data is read before the id, since reading the id frees the hold
  task automatic rx_try(input logic [6:0] s, input logic take);
    cnmc_frame_s f;
    int          n0;
    f = '{id: {4'h4, s}, len: 4'h8, data: {$urandom, $urandom}};
    n0 = stored_n;
    core.send_rx(f);
    repeat (2) @(posedge clock_in);
    chk(64'(stored_n - n0), 64'(take));
    if (take) rd(4'h9, f.data[31:0]);
    rd(4'h8, take ? {12'h0, f.len, 5'h0, f.id} : 32'h0);
  endtask : rx_try
  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////
  // Result watcher: oldest note against each read or accepted frame
  always @(posedge clock_in) begin : mon
    cnmc_frame_s ef;
    if (rstn_in && read && !wait_req) chk(64'(rdata), 64'(exp_rd.pop_front()));
    if (rstn_in && rx_stored) stored_n++;
    if (rstn_in && tx_valid && tx_ready) begin
      ef = (exp_tx.size() != 0) ? exp_tx.pop_front() : '{id: 11'h7ff, len: 4'hf, data: '1};
      chk({49'h0, tx_frame.id, tx_frame.len}, {49'h0, ef.id, ef.len});
      chk(tx_frame.data & ((ef.len == 4'h1) ? 64'hff : '1), ef.data);
    end
  end
  // Hang guard: the run needs one 1 ms tick plus a few hundred cycles
  initial begin
    repeat (75000) @(posedge clock_in);
    err_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(32'hc3d1f0b6));
    {rstn_in, read, write, usb_excl, usb_pres} = 5'h0;
    address = 4'h0;
    wdata = 32'h0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(negedge clock_in);
    chk(64'(rate), 64'h4);
    chk(64'(can_en), 64'h0);
    foreach (nv[i]) begin
      bus(1'b1, 4'h1, {25'h0, nv[i]});
      rd(4'h1, {25'h0, ne[i]});
    end
    for (int r = 0; r < 6; r++) begin
      bus(1'b1, 4'h2, 32'(r));
      settle(0);
      chk(64'(rate), (r < 5) ? 64'(r) : 64'h4);
    end
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b1, 4'h0, 32'h5);
    rd(4'h0, 32'h1);
    settle(0);
    chk(64'(can_en), 64'h1);
    lo = $urandom;
    hi = $urandom;
    bus(1'b1, 4'hb, lo);
    bus(1'b1, 4'hc, hi);
    exp_tx.push_back('{id: 11'h123, len: 4'h8, data: {hi, lo}});
    bus(1'b1, 4'h7, 32'h0008_0123);
    while (exp_tx.size() != 0) @(posedge clock_in);
    for (int m = 1; m < 3; m++) begin
      bus(1'b1, 4'h0, 32'(m));
      bus(1'b1, 4'h5, 32'h0);
      if (m == 1) rx_try(7'($urandom), 1'b1);
      bus(1'b1, 4'h5, 32'h3);
      rx_try(7'h04, 1'b0);
      rx_try(7'h03, 1'b1);
    end
    exp_tx.push_back('{id: 11'h705, len: 4'h1, data: 64'h5});
    exp_tx.push_back('{id: 11'h185, len: 4'h8, data: {hi, lo}});
    bus(1'b1, 4'h3, 32'h1);
    bus(1'b1, 4'h4, 32'h1);
    while (exp_tx.size() != 0) @(posedge clock_in);
    bus(1'b1, 4'h3, 32'h0);
    bus(1'b1, 4'h4, 32'h0);
    usb_excl <= 1'b1;
    settle(5);
    chk(64'(can_en), 64'h1);
    @(posedge clock_in);
    usb_pres <= 1'b1;
    settle(5);
    chk(64'(can_en), 64'h0);
    @(posedge clock_in);
    usb_pres <= 1'b0;
    settle(5);
    chk(64'(can_en), 64'h0);
    @(posedge clock_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    rd(4'h2, 32'h4);
    bus(1'b1, 4'h0, 32'h4);
    settle(0);
    chk(64'(mesh_act), 64'h1);
    chk(64'(can_en), 64'h1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
